// ### hdl/psgp_pkg.sv
// Register map, field positions and timing constants for the power and general pin block
//
// Contract
// - Ring indicate needs three enable bits set and control bit 0 of the second control register clear
// - Otherwise the shared pin signals power event
// - Mode E bit one gates card audio to the speaker only
// - Mux register assigns seven terminal functions
// - Suspend low masks the host reset
// - Power pins serve parallel or serial switch
// - Serial clock input until control bit 13
// - Unmasked host reset clears registers and logic
package psgp_pkg;

  // Timing
  localparam int          CLK_HZ           = 250_000_000;
  localparam int          SCLK_HZ          = 32_000;
  localparam int          SCLK_HALF_CYC    = CLK_HZ / (2 * SCLK_HZ);
  localparam int          SER_BITS_DEF     = 16;

  // Register indices, byte address is four times the index
  localparam logic [9:0]  IDX_POWER_CTL    = 10'h002;
  localparam logic [9:0]  IDX_INT_GEN_CTL  = 10'h003;
  localparam logic [9:0]  IDX_PIN_MUX      = 10'h008;
  localparam logic [9:0]  IDX_MODE_B       = 10'h02e;
  localparam logic [9:0]  IDX_MODE_E       = 10'h03e;
  localparam logic [9:0]  IDX_CTL_TWO      = 10'h0d4;
  localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h0e0;
  localparam logic [9:0]  IDX_IRQ_MASK     = 10'h0e1;
  localparam logic [9:0]  IDX_POWER_WORD   = 10'h0e2;
  localparam logic [9:0]  IDX_PIN_STATUS   = 10'h0e3;

  // Reset values
  localparam logic [7:0]  BYTE_RST         = 8'h00;
  localparam logic [31:0] WORD_RST         = 32'h0000_0000;
  localparam logic [31:0] PWORD_RST        = 32'h0000_0100;
  localparam logic [2:0]  IRQ_RST          = 3'h0;

  // Field positions
  localparam int          RING_EN_BIT      = 7;
  localparam int          CTL2_RING_SEL    = 0;
  localparam int          CTL2_SCLK_OUT    = 13;
  localparam int          MODE_E_AUDIO     = 1;
  localparam int          MF_COUNT         = 7;
  localparam int          MF_FIELD_W       = 4;
  localparam int          ST_WAKE          = 0;
  localparam int          ST_RING          = 1;
  localparam int          ST_SHIFT         = 2;
  localparam int          PW_SUP0          = 0;
  localparam int          PW_SUP1          = 1;
  localparam int          PW_RAIL0         = 2;
  localparam int          PW_RAIL1         = 3;
  localparam int          PW_SERIAL        = 8;
  localparam int          PW_WORD_LSB      = 16;
  localparam int          PS_BUSY          = 8;

  // Terminal function codes
  localparam logic [3:0]  MF_SEL_INPUT     = 4'h0;
  localparam logic [3:0]  MF_SEL_IRQ       = 4'h1;
  localparam logic [3:0]  MF_SEL_AUDIO     = 4'h2;
  localparam logic [3:0]  MF_SEL_LOW       = 4'h3;
  localparam logic [3:0]  MF_SEL_HIGH      = 4'h4;

  typedef enum logic [2:0]
  {
    SH_IDLE  = 3'b001,
    SH_SHIFT = 3'b010,
    SH_LATCH = 3'b100
  } psgp_sh_state_type;

endpackage

// ### hdl/psgp_shift_if.sv
// Handshake between the pin block and its serial power-word shifter
`timescale 1ns/1ns
interface psgp_shift_if #(parameter int BITS = 16);
  logic            start;
  logic            clr;
  logic            tick;
  logic [BITS-1:0] word;
  logic            busy;
  logic            done;
  logic            dout;
  logic            strobe;

  modport ctl (output start, output clr, output tick, output word,
               input busy, input done, input dout, input strobe);
  modport shf (input start, input clr, input tick, input word,
               output busy, output done, output dout, output strobe);
endinterface

// ### hdl/psgp_shifter.sv
// Serial power-word shifter with latch strobe
`timescale 1ns/1ns
module psgp_shifter
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  // Control side
  psgp_shift_if.shf bus
);
  import psgp_pkg::*;

  localparam int BITS = $bits(bus.word);
  localparam int CW   = $clog2(BITS + 1);

  psgp_sh_state_type state_ff;
  psgp_sh_state_type nxt_state;
  logic [BITS-1:0]   sh_ff;
  logic [BITS-1:0]   nxt_sh;
  logic [CW-1:0]     cnt_ff;
  logic [CW-1:0]     nxt_cnt;
  logic              dout_ff;
  logic              nxt_dout;
  logic              stb_ff;
  logic              nxt_stb;
  logic              done_ff;
  logic              nxt_done;

  // Data changes on the falling serial edge so the switch samples mid-bit
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sh    = sh_ff;
    nxt_cnt   = cnt_ff;
    nxt_dout  = dout_ff;
    nxt_stb   = stb_ff;
    nxt_done  = 1'b0;
    if (bus.clr)
    begin
      nxt_state = SH_IDLE;
      nxt_cnt   = '0;
      nxt_dout  = 1'b0;
      nxt_stb   = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        SH_IDLE:
          if (bus.start)
          begin
            nxt_sh    = bus.word;
            nxt_cnt   = '0;
            nxt_state = SH_SHIFT;
          end
        SH_SHIFT:
          if (bus.tick)
          begin
            if (cnt_ff == CW'(BITS))
            begin
              nxt_stb   = 1'b1;
              nxt_state = SH_LATCH;
            end
            else
            begin
              nxt_dout = sh_ff[BITS-1];
              nxt_sh   = {sh_ff[BITS-2:0], 1'b0};
              nxt_cnt  = cnt_ff + CW'(1);
            end
          end
        SH_LATCH:
          if (bus.tick)
          begin
            nxt_stb   = 1'b0;
            nxt_done  = 1'b1;
            nxt_state = SH_IDLE;
          end
        default:
          nxt_state = SH_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= SH_IDLE;
      sh_ff    <= '0;
      cnt_ff   <= '0;
      dout_ff  <= 1'b0;
      stb_ff   <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sh_ff    <= nxt_sh;
      cnt_ff   <= nxt_cnt;
      dout_ff  <= nxt_dout;
      stb_ff   <= nxt_stb;
      done_ff  <= nxt_done;
    end
  end

  assign bus.busy   = (state_ff != SH_IDLE);
  assign bus.done   = done_ff;
  assign bus.dout   = dout_ff;
  assign bus.strobe = stb_ff;

  latch_after_bits_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(stb_ff) |-> $past(cnt_ff) == CW'(BITS))
    else $error("latch strobe rose before all bits were shifted");

  strobe_holds_a: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    stb_ff && !bus.tick && !bus.clr |=> stb_ff)
    else $error("latch strobe dropped before a full serial period");

endmodule

// ### hdl/psgp_pins.sv
// Power switch and general pin block with APB register access
`timescale 1ns/1ns
module psgp_pins
#(
  parameter int SER_BITS  = psgp_pkg::SER_BITS_DEF,
  parameter int SCLK_HALF = psgp_pkg::SCLK_HALF_CYC
)
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  // Host and card side inputs
  input  wire logic        pci_rst_n_i,
  input  wire logic        suspend_n_i,
  input  wire logic        card_ring_i,
  input  wire logic        card_audio_i,
  input  wire logic        card_wake_i,
  // Shared wake pin and speaker
  output logic             ring_indicate_output_o,
  output logic             audio_tone_out_n_o,
  // Multifunction terminals
  input  wire logic [psgp_pkg::MF_COUNT-1:0] multi_use_terminals_i,
  output logic      [psgp_pkg::MF_COUNT-1:0] multi_use_terminals_o,
  output logic      [psgp_pkg::MF_COUNT-1:0] multi_use_terminals_oe_n_o,
  // Power switch pins, parallel or serial
  output logic             prog_supply_sel0_o,
  output logic             prog_supply_sel1_o,
  output logic             rail_sel0_n_o,
  input  wire logic        rail_sel1_n_i,
  output logic             rail_sel1_n_o,
  output logic             rail_sel1_n_oe_n_o
);
  import psgp_pkg::*;

  localparam int SW = MF_COUNT + 6;
  localparam int DW = $clog2(SCLK_HALF + 1);

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] mf_dec(input logic [3:0] code, input logic irq,
                                        input logic aud);
    unique case (code)
      MF_SEL_IRQ:   mf_dec = {1'b1, irq};
      MF_SEL_AUDIO: mf_dec = {1'b1, aud};
      MF_SEL_LOW:   mf_dec = 2'b10;
      MF_SEL_HIGH:  mf_dec = 2'b11;
      default:      mf_dec = 2'b00;
    endcase
  endfunction

  // Pin synchronisers; only the second stage is read
  logic [SW-1:0] s1_ff;
  logic [SW-1:0] s2_ff;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= {multi_use_terminals_i, rail_sel1_n_i, card_wake_i, card_audio_i,
                card_ring_i, suspend_n_i, pci_rst_n_i};
      s2_ff <= s1_ff;
    end
  end

  logic               rst_s;
  logic               susp_s;
  logic               ring_s;
  logic               audio_s;
  logic               wake_s;
  logic               sclk_s;
  logic [MF_COUNT-1:0] mf_s;
  assign {mf_s, sclk_s, wake_s, audio_s, ring_s, susp_s, rst_s} = s2_ff;

  psgp_shift_if #(.BITS(SER_BITS)) sh_bus ();

  psgp_shifter u_shifter
  (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .bus       (sh_bus.shf)
  );

  logic [7:0]          pwr_ff, igc_ff, mcb_ff, mde_ff;
  logic [7:0]          nxt_pwr, nxt_igc, nxt_mcb, nxt_mde;
  logic [31:0]         mux_ff, ctl2_ff, pword_ff, rdata_ff;
  logic [31:0]         nxt_mux, nxt_ctl2, nxt_pword, nxt_rdata;
  logic [2:0]          sts_ff, msk_ff, nxt_sts, nxt_msk;
  logic                pend_ff, nxt_pend, err_ff, nxt_err, irq_ff, nxt_irq;
  logic                ring_d_ff, wake_d_ff, sclk_d_ff, iclk_ff, nxt_iclk;
  logic [DW-1:0]       div_ff, nxt_div;
  logic                ri_ff, aud_ff, sel0_ff, sel1_ff, rail0_ff, rail1_ff, r1oe_ff;
  logic                nxt_ri, nxt_aud, nxt_sel0, nxt_sel1, nxt_rail0, nxt_rail1, nxt_r1oe;
  logic [MF_COUNT-1:0] mfo_ff, mfoe_ff, nxt_mfo, nxt_mfoe;
  logic                soft_rst, wr, ring_mode, serial, int_fall;
  logic [2:0]          ev;

  // Host reset is honoured only while suspend is high
  assign soft_rst  = !rst_s && susp_s;
  assign wr        = psel_i && penable_i && pwrite_i;
  assign ring_mode = mcb_ff[RING_EN_BIT] && pwr_ff[RING_EN_BIT] && igc_ff[RING_EN_BIT]
                     && !ctl2_ff[CTL2_RING_SEL];
  assign serial    = pword_ff[PW_SERIAL];
  assign int_fall  = (div_ff == DW'(SCLK_HALF - 1)) && iclk_ff;
  assign ev        = {sh_bus.done, ring_s && !ring_d_ff, wake_s && !wake_d_ff};

  // Falling serial edge from the pin or the internal divider, per direction bit
  assign sh_bus.tick  = serial && (ctl2_ff[CTL2_SCLK_OUT] ? int_fall
                                                          : (sclk_d_ff && !sclk_s));
  assign sh_bus.start = pend_ff && serial && !sh_bus.busy;
  // Leaving serial form abandons a cut frame so the shifter never hangs busy
  assign sh_bus.clr   = soft_rst || !serial;
  assign sh_bus.word  = pword_ff[PW_WORD_LSB +: SER_BITS];

  genvar gi;
  generate
    for (gi = 0; gi < MF_COUNT; gi++)
    begin : g_mf
      logic [1:0] dec;
      assign dec          = mf_dec(mux_ff[gi*MF_FIELD_W +: MF_FIELD_W], !irq_ff, !audio_s);
      assign nxt_mfo[gi]  = dec[0];
      assign nxt_mfoe[gi] = !dec[1];
    end
  endgenerate

  always_comb
  begin
    nxt_pwr   = pwr_ff;
    nxt_igc   = igc_ff;
    nxt_mcb   = mcb_ff;
    nxt_mde   = mde_ff;
    nxt_mux   = mux_ff;
    nxt_ctl2  = ctl2_ff;
    nxt_pword = pword_ff;
    nxt_msk   = msk_ff;
    nxt_sts   = sts_ff;
    nxt_pend  = pend_ff && !sh_bus.start;
    nxt_rdata = rdata_ff;
    nxt_err   = err_ff;
    if (wr && hit(paddr_i, IDX_POWER_CTL))   nxt_pwr  = pwdata_i[7:0];
    if (wr && hit(paddr_i, IDX_INT_GEN_CTL)) nxt_igc  = pwdata_i[7:0];
    if (wr && hit(paddr_i, IDX_PIN_MUX))     nxt_mux  = pwdata_i;
    if (wr && hit(paddr_i, IDX_MODE_B))      nxt_mcb  = pwdata_i[7:0];
    if (wr && hit(paddr_i, IDX_MODE_E))      nxt_mde  = pwdata_i[7:0];
    if (wr && hit(paddr_i, IDX_CTL_TWO))     nxt_ctl2 = pwdata_i;
    if (wr && hit(paddr_i, IDX_IRQ_MASK))    nxt_msk  = pwdata_i[2:0];
    if (wr && hit(paddr_i, IDX_IRQ_STATUS))  nxt_sts  = sts_ff & ~pwdata_i[2:0];
    // Events win over a clear in the same cycle
    nxt_sts = nxt_sts | ev;
    if (wr && hit(paddr_i, IDX_POWER_WORD))
    begin
      nxt_pword = pwdata_i;
      nxt_pend  = pwdata_i[PW_SERIAL];
    end
    // Read data and error are sampled in the setup phase
    if (psel_i && !penable_i)
    begin
      nxt_err = 1'b0;
      unique case (paddr_i[11:2])
        IDX_POWER_CTL:   nxt_rdata = {24'h00_0000, pwr_ff};
        IDX_INT_GEN_CTL: nxt_rdata = {24'h00_0000, igc_ff};
        IDX_PIN_MUX:     nxt_rdata = mux_ff;
        IDX_MODE_B:      nxt_rdata = {24'h00_0000, mcb_ff};
        IDX_MODE_E:      nxt_rdata = {24'h00_0000, mde_ff};
        IDX_CTL_TWO:     nxt_rdata = ctl2_ff;
        IDX_IRQ_STATUS:  nxt_rdata = {29'h0000_0000, sts_ff};
        IDX_IRQ_MASK:    nxt_rdata = {29'h0000_0000, msk_ff};
        IDX_POWER_WORD:  nxt_rdata = pword_ff;
        IDX_PIN_STATUS:  nxt_rdata = {23'h00_0000, sh_bus.busy, 1'b0, mf_s};
        default:
        begin
          nxt_rdata = WORD_RST;
          nxt_err   = 1'b1;
        end
      endcase
      if (paddr_i[1:0] != 2'b00)
      begin
        nxt_rdata = WORD_RST;
        nxt_err   = 1'b1;
      end
    end
    if (soft_rst)
    begin
      nxt_pwr   = BYTE_RST;
      nxt_igc   = BYTE_RST;
      nxt_mcb   = BYTE_RST;
      nxt_mde   = BYTE_RST;
      nxt_mux   = WORD_RST;
      nxt_ctl2  = WORD_RST;
      nxt_pword = PWORD_RST;
      nxt_msk   = IRQ_RST;
      nxt_sts   = IRQ_RST;
      nxt_pend  = 1'b0;
    end
    nxt_irq  = |(nxt_sts & nxt_msk);
    nxt_div  = (div_ff == DW'(SCLK_HALF - 1)) ? '0 : div_ff + DW'(1);
    nxt_iclk = (div_ff == DW'(SCLK_HALF - 1)) ? !iclk_ff : iclk_ff;
    // Pin values
    nxt_ri    = ring_mode ? ring_s : !sts_ff[ST_WAKE];
    nxt_aud   = mde_ff[MODE_E_AUDIO] ? !audio_s : 1'b1;
    nxt_sel0  = serial ? sh_bus.strobe : pword_ff[PW_SUP0];
    nxt_sel1  = pword_ff[PW_SUP1];
    nxt_rail0 = serial ? sh_bus.dout : pword_ff[PW_RAIL0];
    nxt_rail1 = serial ? iclk_ff : pword_ff[PW_RAIL1];
    nxt_r1oe  = serial ? !ctl2_ff[CTL2_SCLK_OUT] : 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pwr_ff    <= BYTE_RST;
      igc_ff    <= BYTE_RST;
      mcb_ff    <= BYTE_RST;
      mde_ff    <= BYTE_RST;
      mux_ff    <= WORD_RST;
      ctl2_ff   <= WORD_RST;
      pword_ff  <= PWORD_RST;
      msk_ff    <= IRQ_RST;
      sts_ff    <= IRQ_RST;
      pend_ff   <= 1'b0;
      rdata_ff  <= WORD_RST;
      err_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      ring_d_ff <= 1'b0;
      wake_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      div_ff    <= '0;
      iclk_ff   <= 1'b0;
      ri_ff     <= 1'b1;
      aud_ff    <= 1'b1;
      mfo_ff    <= '0;
      mfoe_ff   <= '1;
      sel0_ff   <= 1'b0;
      sel1_ff   <= 1'b0;
      rail0_ff  <= 1'b1;
      rail1_ff  <= 1'b1;
      r1oe_ff   <= 1'b1;
    end
    else
    begin
      pwr_ff    <= nxt_pwr;
      igc_ff    <= nxt_igc;
      mcb_ff    <= nxt_mcb;
      mde_ff    <= nxt_mde;
      mux_ff    <= nxt_mux;
      ctl2_ff   <= nxt_ctl2;
      pword_ff  <= nxt_pword;
      msk_ff    <= nxt_msk;
      sts_ff    <= nxt_sts;
      pend_ff   <= nxt_pend;
      rdata_ff  <= nxt_rdata;
      err_ff    <= nxt_err;
      irq_ff    <= nxt_irq;
      ring_d_ff <= ring_s;
      wake_d_ff <= wake_s;
      sclk_d_ff <= sclk_s;
      div_ff    <= nxt_div;
      iclk_ff   <= nxt_iclk;
      ri_ff     <= nxt_ri;
      aud_ff    <= nxt_aud;
      mfo_ff    <= nxt_mfo;
      mfoe_ff   <= nxt_mfoe;
      sel0_ff   <= nxt_sel0;
      sel1_ff   <= nxt_sel1;
      rail0_ff  <= nxt_rail0;
      rail1_ff  <= nxt_rail1;
      r1oe_ff   <= nxt_r1oe;
    end
  end

  // Zero wait states keeps the slave simple; data is already registered
  assign pready_o                   = 1'b1;
  assign prdata_o                   = rdata_ff;
  assign pslverr_o                  = err_ff && psel_i && penable_i;
  assign irq_o                      = irq_ff;
  assign ring_indicate_output_o     = ri_ff;
  assign audio_tone_out_n_o         = aud_ff;
  assign multi_use_terminals_o      = mfo_ff;
  assign multi_use_terminals_oe_n_o = mfoe_ff;
  assign prog_supply_sel0_o         = sel0_ff;
  assign prog_supply_sel1_o         = sel1_ff;
  assign rail_sel0_n_o              = rail0_ff;
  assign rail_sel1_n_o              = rail1_ff;
  assign rail_sel1_n_oe_n_o         = r1oe_ff;

  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  ring_select_a: assert property (ring_mode |=> ring_indicate_output_o == $past(ring_s))
    else $error("shared pin not following ring in ring mode");

  wake_event_a: assert property (!ring_mode && sts_ff[ST_WAKE] |=> !ring_indicate_output_o)
    else $error("power event not driven low on shared pin");

  audio_gate_a: assert property (!mde_ff[MODE_E_AUDIO] |=> audio_tone_out_n_o)
    else $error("speaker driven while audio disabled");

  mux_input_a: assert property (mux_ff[MF_FIELD_W-1:0] == MF_SEL_INPUT
                                |=> multi_use_terminals_oe_n_o[0])
    else $error("terminal zero driven while set as input");

  suspend_mask_a: assert property (!rst_s && !susp_s && !wr |=> $stable(ctl2_ff))
    else $error("registers changed under masked host reset");

  host_reset_a: assert property (soft_rst |=> ctl2_ff == WORD_RST && mux_ff == WORD_RST
                                 && pword_ff == PWORD_RST)
    else $error("host reset did not clear registers");

  parallel_pins_a: assert property (!serial |=> prog_supply_sel0_o == $past(pword_ff[PW_SUP0])
                                    && rail_sel0_n_o == $past(pword_ff[PW_RAIL0]))
    else $error("parallel select lines not following power word");

  sclk_dir_a: assert property (serial && !ctl2_ff[CTL2_SCLK_OUT] |=> rail_sel1_n_oe_n_o)
    else $error("serial clock pin driven while in input mode");

endmodule

// ### tb/psgp_switch_model.sv
// Behavioural model of the external serial power switch
`timescale 1ns/1ns
module psgp_switch_model
#(
  parameter int BITS    = 16,
  parameter int HALF_NS = 24
)
(
  // Pins seen by the switch
  input  wire logic            sclk_i,
  input  wire logic            serial_power_dout_i,
  input  wire logic            strobe_i,
  // Reference clock supplied and word taken
  output logic                 ref_sclk_o,
  output logic      [BITS-1:0] word_o
);
  logic [BITS-1:0] shift_ff;

  // Free running, as a reference oscillator would be
  initial
  begin
    ref_sclk_o = 1'h1;
    forever #(HALF_NS) ref_sclk_o = ~ref_sclk_o;
  end

  // Msb first, sampled mid bit on the rising clock edge
  always @(posedge sclk_i)
    if (!strobe_i)
      shift_ff <= {shift_ff[BITS-2:0], serial_power_dout_i};

  // Only the last BITS bits before the strobe count
  always @(posedge strobe_i)
    word_o <= shift_ff;
endmodule

// ### tb/tb.sv
// Self-checking bench for the power switch and general pin block
`timescale 1ns/1ns
module tb;
  import psgp_pkg::*;
  typedef struct packed {logic [63:0] m; logic [63:0] e;} psgp_note_type;
  localparam logic [11:0] DA [6] = '{12'h008, 12'h00c, 12'h020, 12'h0b8, 12'h0f8, 12'h350};
  localparam logic [31:0] DM [6] = '{32'hff, 32'hff, 32'hffffffff, 32'hff, 32'hff, 32'hffffffff};
  localparam logic [11:0] IST = 12'h380, IMK = 12'h384, PW = 12'h388, PS = 12'h38c;

  logic          ref_clk_i, arst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o;
  logic [11:0]   paddr_i;
  logic [31:0]   pwdata_i, prdata_o, r;
  logic          pci_rst_n_i, suspend_n_i, card_ring_i, card_audio_i, card_wake_i;
  logic          ring_o, aud_o, sel0_o, sel1_o, rail0_o, rail1_o, rail1_oe_n, rail1_w, sw_clk;
  logic [6:0]    mf_o, mf_oe_n, mf_drv, mf_w;
  logic [15:0]   sw_word;
  logic [63:0]   pins_w;
  psgp_note_type note_q[$];
  int            num_errors, comparisons, seed;
  event          pin_ev;

  // Shared pins resolve to whoever is driving them
  assign mf_w = (mf_oe_n & mf_drv) | (~mf_oe_n & mf_o);
  assign rail1_w = rail1_oe_n ? sw_clk : rail1_o;
  assign pins_w = {sw_word, 26'h0, irq_o, ring_o, aud_o, sel0_o, sel1_o, rail0_o, rail1_o,
                   rail1_oe_n, mf_oe_n, mf_o};

  psgp_pins #(.SER_BITS(16), .SCLK_HALF(4)) u_dut
  (
    .ref_clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .irq_o, .pci_rst_n_i, .suspend_n_i, .card_ring_i, .card_audio_i,
    .card_wake_i, .ring_indicate_output_o(ring_o), .audio_tone_out_n_o(aud_o),
    .multi_use_terminals_i(mf_w), .multi_use_terminals_o(mf_o),
    .multi_use_terminals_oe_n_o(mf_oe_n), .prog_supply_sel0_o(sel0_o),
    .prog_supply_sel1_o(sel1_o), .rail_sel0_n_o(rail0_o), .rail_sel1_n_i(rail1_w),
    .rail_sel1_n_o(rail1_o), .rail_sel1_n_oe_n_o(rail1_oe_n)
  );

  psgp_switch_model #(.BITS(16), .HALF_NS(24)) u_sw
  (
    .sclk_i(rail1_w), .serial_power_dout_i(rail0_o), .strobe_i(sel0_o), .ref_sclk_o(sw_clk),
    .word_o(sw_word)
  );

  task automatic judge(input logic [63:0] o);
    psgp_note_type n;
    n = note_q.pop_front();
    comparisons++;
    if ((o & n.m) !== (n.e & n.m))
    begin
      num_errors++;
      $display("[FAIL] %0t expected %h got %h", $time, n.e & n.m, o & n.m);
    end
  endtask

  always @(posedge ref_clk_i)
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'h1)
      judge({31'h0, pslverr_o, prdata_o});

  always
  begin
    @(pin_ev);
    judge(pins_w);
  end

  // One idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'h1;
    do
      @(posedge ref_clk_i);
    while (pready_o !== 1'h1);
    psel_i <= 1'h0;
    penable_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    note_q.push_back('{m: '1, e: {31'h0, err, e}});
    apb(1'h0, a, 32'h0);
  endtask

  // Settle covers the two-flop input sync plus the output register
  task automatic pinv(input logic [63:0] m, input logic [63:0] e);
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    note_q.push_back('{m: m, e: e});
    -> pin_ev;
    @(posedge ref_clk_i);
  endtask

  task automatic pin(input int p, input logic v);
    pinv(64'h1 << p, 64'(v) << p);
  endtask

  task automatic rcfg(input logic [3:0] k);
    wr(12'h0b8, {24'h0, k[0], 7'h0});
    wr(12'h008, {24'h0, k[1], 7'h0});
    wr(12'h00c, {24'h0, k[2], 7'h0});
    wr(12'h350, {31'h0, k[3]});
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 4000 && irq_o !== 1'h1; n++)
      @(posedge ref_clk_i);
  endtask

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    #100000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  initial
  begin
    seed = 72;
    num_errors = 0;
    comparisons = 0;
    {psel_i, penable_i, pwrite_i, card_ring_i, card_audio_i, card_wake_i} = 6'h00;
    {arst_n_i, pci_rst_n_i, suspend_n_i} = 3'h3;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    mf_drv = 7'h00;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    @(posedge ref_clk_i);
    for (int i = 0; i < 6; i++)
      rd(DA[i], 32'h0, 1'h0);
    rd(PW, PWORD_RST, 1'h0);
    pinv(64'h1f7f80, 64'h187f80);
    for (int i = 0; i < 6; i++)
    begin
      r = $random(seed);
      wr(DA[i], r);
      rd(DA[i], r & DM[i], 1'h0);
      wr(DA[i], 32'h0);
    end
    rd(12'h3fc, 32'h0, 1'h1);
    r = $random(seed);
    mf_drv <= r[6:0];
    wr(PS, 32'hffffffff);
    rd(PS, {25'h0, r[6:0]}, 1'h0);
    for (int k = 0; k < 16; k++)
    begin
      rcfg(k[3:0]);
      pin(20, k != 7);
    end
    rcfg(4'h7);
    card_ring_i <= 1'h1;
    pin(20, 1'h1);
    card_ring_i <= 1'h0;
    rd(IST, 32'h2, 1'h0);
    wr(IST, 32'h2);
    rd(IST, 32'h0, 1'h0);
    rcfg(4'h0);
    card_wake_i <= 1'h1;
    pinv(64'h3 << 20, 64'h0);
    wr(IMK, 32'h1);
    pin(21, 1'h1);
    card_wake_i <= 1'h0;
    wr(IST, 32'h1);
    pinv(64'h3 << 20, 64'h1 << 20);
    wr(IMK, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(12'h0f8, {30'h0, k[1], 1'h0});
      card_audio_i <= k[0];
      pin(19, k[1] ? !k[0] : 1'h1);
    end
    wr(12'h020, 32'h0354_3210);
    pinv({7'h7f, 7'h5e}, {7'h21, 7'h12});
    wr(12'h020, 32'h0);
    r = $random(seed);
    wr(PW, {28'h0, r[3:0]});
    pinv(64'h1f << 14, 64'({r[0], r[1], r[2], r[3], 1'h0}) << 14);
    wr(IMK, 32'h4);
    for (int j = 0; j < 2; j++)
    begin
      wr(12'h350, {18'h0, j[0], 13'h0});
      r = $random(seed);
      wr(PW, {r[15:0], 16'h0100});
      pin(14, !j[0]);
      wait_irq();
      pinv({16'hffff, 26'h0, 1'h1, 21'h0}, {r[15:0], 26'h0, 1'h1, 21'h0});
      wr(IST, 32'h4);
    end
    wr(12'h0f8, 32'h2);
    suspend_n_i <= 1'h0;
    repeat (4) @(posedge ref_clk_i);
    pci_rst_n_i <= 1'h0;
    repeat (6) @(posedge ref_clk_i);
    rd(12'h0f8, 32'h2, 1'h0);
    pci_rst_n_i <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    suspend_n_i <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    pci_rst_n_i <= 1'h0;
    repeat (6) @(posedge ref_clk_i);
    pci_rst_n_i <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    rd(12'h0f8, 32'h0, 1'h0);
    rd(PW, PWORD_RST, 1'h0);
    final_report();
  end
endmodule
